/* File: hw/ebc_defs.vh */
// Purpose: Shared constants for the external bus control block.
// Assumes: Core clock of 40 MHz; all counts in core clock cycles.
// Notes:   Definitions only.
`ifndef EBC_DEFS_VH
`define EBC_DEFS_VH

// =============================================================
// Arbitration and cycle states
// =============================================================
`define EBC_ST_IDLE 3'h0
`define EBC_ST_WAITBB 3'h1
`define EBC_ST_OWN 3'h2
`define EBC_ST_WAIT 3'h3
`define EBC_ST_ACK 3'h4
`define EBC_ST_DONE 3'h5

// =============================================================
// Widths and reset values
// =============================================================
`define EBC_ATTR_W 4
`define EBC_WS_W 4
`define EBC_ATTR_IDLE 4'h0
`define EBC_WS_ZERO 4'h0
`define EBC_WS_ONE 4'h1

`endif

/* File: hw/ebc_sync2.v */
// Purpose: Two-stage synchroniser for one level into the core clock.
// Assumes: Input may change at any time relative to clk.
// Notes:   The first stage feeds only the second stage.
`default_nettype none

module ebc_sync2 #(
    parameter RESET_VAL = 1'b1
) (
    input wire clk,
    input wire sys_rst,
    input wire din,
    output wire dout
);

    reg stage1;
    reg stage2;

    // =============================================================
    // Synchroniser chain
    // =============================================================
    // Two flops give a metastable first stage a full cycle to settle.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
        end
    end

    assign dout = stage2;

endmodule

`default_nettype wire

/* File: hw/ebc_bus_control.v */
// Purpose: Control side of an external memory expansion port.
// Assumes: All inputs synchronous to clk except the transfer acknowledge,
//          which may be synchronised here on request.
// Notes:   Two-way pins are split into input, output and output enable.
`default_nettype none
`include "ebc_defs.vh"

// Summary of operation
// - By default at most one attribute line is asserted at a time.
// - Priority disable drives the four attribute lines as an encoded code.
// - In row strobe mode, lines are tri-statable with programmable polarity.
// - Read strobe asserted low only while owning the bus, else released.
// - Write strobe asserted low only while owning the bus, else released.
// - Acknowledge ignored when not owner or no external cycle running.
// - Held-off acknowledge stretches a non-DRAM cycle with waits by any number of waits.
// - Cycle ends one clock after acknowledge is seen asserted.
// - Non-DRAM cycle with waits lasts the longer of programmed waits and acknowledge demand.
// - Acknowledge sampled synchronously or asynchronously by select input.
// - Bus request asserted while the bus is needed, dropped otherwise.
// - Bus request independent of ownership; may drop while parked.
// - Request hold keeps bus request asserted without pending access.
// - Bus request raised only for external, never internal, accesses.
// - Reset deasserts bus request and returns arbitration to non-owner.
// - Standby drops request if hold clear, keeps last level if set.
// - After grant, wait for bus busy released before taking ownership.
// - Owner may keep bus busy asserted after activity ends (parking).
// - Standby gives up ownership and releases strobes and busy.
module ebc_bus_control #(
    parameter ATTR_W = `EBC_ATTR_W,
    parameter WS_W = `EBC_WS_W
) (
    input wire clk,
    input wire sys_rst,
    // Core side access request.
    input wire accReq,
    input wire accExternal,
    input wire accWrite,
    input wire [ATTR_W-1:0] accAttr,
    input wire accDram,
    output wire accDone,
    output wire busOwner,
    // Configuration bits.
    input wire attrPriorityDisable,
    input wire rowStrobeMode,
    input wire [ATTR_W-1:0] rowStrobeActiveHigh,
    input wire ackSyncSelect,
    input wire requestHold,
    input wire parkEnable,
    input wire [WS_W-1:0] waitStates,
    input wire standby,
    // Pins.
    output reg [ATTR_W-1:0] addressAttributeOut,
    output reg addressAttributeOe,
    output reg readStrobe_n,
    output reg writeStrobe_n,
    output reg strobeOe,
    input wire transferAck_n,
    output reg busRequest_n,
    input wire busGrant_n,
    input wire busBusyIn_n,
    output reg busBusyOut_n,
    output reg busBusyOe
);

    reg [2:0] state;
    reg [2:0] next_state;
    reg [WS_W-1:0] waitCnt;
    reg [WS_W-1:0] next_waitCnt;
    reg cycWrite;
    reg [ATTR_W-1:0] cycAttr;
    reg cycDram;
    reg [ATTR_W-1:0] attrDrive;
    reg [ATTR_W-1:0] attrOneHot;
    reg next_busRequest_n;
    reg busBusyRelease;
    wire ackSynced_n;
    wire ackSeen;
    wire ownsBus;
    wire inCycle;
    wire extNeed;
    integer i;

    // =============================================================
    // Acknowledge sampling
    // =============================================================
    // Asynchronous acknowledge goes through two flops first.
    ebc_sync2 #(
        .RESET_VAL(1'b1)
    ) uAckSync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(transferAck_n),
        .dout(ackSynced_n)
    );

    // Select between direct and synchronised acknowledge.
    assign ackSeen = ackSyncSelect ? ~transferAck_n : ~ackSynced_n;

    // =============================================================
    // Ownership and request
    // =============================================================
    assign ownsBus = (state == `EBC_ST_OWN) || (state == `EBC_ST_WAIT) ||
                     (state == `EBC_ST_ACK) || (state == `EBC_ST_DONE);
    assign inCycle = (state == `EBC_ST_WAIT) || (state == `EBC_ST_ACK);
    assign extNeed = accReq & accExternal;
    assign busOwner = ownsBus;
    assign accDone = (state == `EBC_ST_DONE);

    // Next request level; active low, independent of ownership.
    always @* begin
        if (standby) begin
            if (requestHold) begin
                next_busRequest_n = busRequest_n;
            end else begin
                next_busRequest_n = 1'b1;
            end
        end else if (requestHold) begin
            next_busRequest_n = 1'b0;
        end else if (extNeed && (state != `EBC_ST_DONE)) begin
            next_busRequest_n = 1'b0;
        end else begin
            next_busRequest_n = 1'b1;
        end
    end

    // =============================================================
    // Arbitration and cycle state machine
    // =============================================================
    always @* begin
        next_state = state;
        next_waitCnt = waitCnt;
        case (state)
            `EBC_ST_IDLE: begin
                if (!standby && !busGrant_n) begin
                    next_state = `EBC_ST_WAITBB;
                end
            end
            `EBC_ST_WAITBB: begin
                if (standby || busGrant_n) begin
                    next_state = `EBC_ST_IDLE;
                end else if (busBusyIn_n) begin
                    next_state = `EBC_ST_OWN;
                end
            end
            `EBC_ST_OWN: begin
                if (standby) begin
                    next_state = `EBC_ST_IDLE;
                end else if (extNeed) begin
                    next_waitCnt = waitStates;
                    if (waitStates == `EBC_WS_ZERO) begin
                        next_state = `EBC_ST_DONE;
                    end else begin
                        next_state = `EBC_ST_WAIT;
                    end
                end else if (busGrant_n && !parkEnable) begin
                    next_state = `EBC_ST_IDLE;
                end else if (busGrant_n) begin
                    next_state = `EBC_ST_IDLE;
                end
            end
            `EBC_ST_WAIT: begin
                // Programmed minimum counts down before acknowledge counts.
                if (waitCnt > `EBC_WS_ONE) begin
                    next_waitCnt = waitCnt - `EBC_WS_ONE;
                end else begin
                    next_state = `EBC_ST_ACK;
                end
            end
            `EBC_ST_ACK: begin
                // Stretch non-DRAM cycles while acknowledge is held off; DRAM cycles end at once.
                if (ackSeen && !cycDram) begin
                    next_state = `EBC_ST_DONE;
                end else if (cycDram) begin
                    next_state = `EBC_ST_DONE;
                end else begin
                    next_state = `EBC_ST_ACK;
                end
            end
            `EBC_ST_DONE: begin
                if (standby || busGrant_n) begin
                    next_state = `EBC_ST_IDLE;
                end else begin
                    next_state = `EBC_ST_OWN;
                end
            end
            default: begin
                next_state = `EBC_ST_IDLE;
            end
        endcase
    end

    // State, counter and captured access attributes.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= `EBC_ST_IDLE;
            waitCnt <= `EBC_WS_ZERO;
            cycWrite <= 1'b0;
            cycAttr <= `EBC_ATTR_IDLE;
            cycDram <= 1'b0;
            busRequest_n <= 1'b1;
        end else begin
            state <= next_state;
            waitCnt <= next_waitCnt;
            busRequest_n <= next_busRequest_n;
            if (state == `EBC_ST_OWN && extNeed && !standby) begin
                cycWrite <= accWrite;
                cycAttr <= accAttr;
                cycDram <= accDram;
            end
        end
    end

    // =============================================================
    // Attribute encoding
    // =============================================================
    // Lowest numbered requested line wins in priority mode.
    always @* begin
        attrOneHot = `EBC_ATTR_IDLE;
        for (i = ATTR_W - 1; i >= 0; i = i - 1) begin
            if (cycAttr[i]) begin
                attrOneHot = {ATTR_W{1'b0}};
                attrOneHot[i] = 1'b1;
            end
        end
        if (rowStrobeMode) begin
            // Row strobes take the captured pattern with set polarity.
            attrDrive = ~(cycAttr ^ rowStrobeActiveHigh);
        end else if (attrPriorityDisable) begin
            attrDrive = cycAttr;
        end else begin
            attrDrive = attrOneHot;
        end
    end

    // =============================================================
    // Pin drivers
    // =============================================================
    // Strobes and attributes are registered; released when not owner.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addressAttributeOut <= `EBC_ATTR_IDLE;
            addressAttributeOe <= 1'b0;
            readStrobe_n <= 1'b1;
            writeStrobe_n <= 1'b1;
            strobeOe <= 1'b0;
            busBusyOut_n <= 1'b1;
            busBusyOe <= 1'b0;
            busBusyRelease <= 1'b0;
        end else begin
            addressAttributeOe <= (next_state != `EBC_ST_IDLE) &&
                                  (next_state != `EBC_ST_WAITBB);
            strobeOe <= (next_state != `EBC_ST_IDLE) &&
                        (next_state != `EBC_ST_WAITBB);
            if (inCycle || (state == `EBC_ST_OWN && next_state ==
                `EBC_ST_WAIT)) begin
                addressAttributeOut <= attrDrive;
            end
            // Active-low strobes only during an owned cycle.
            if (next_state == `EBC_ST_WAIT || next_state == `EBC_ST_ACK ||
                (next_state == `EBC_ST_DONE && state == `EBC_ST_OWN)) begin
                readStrobe_n <= (state == `EBC_ST_OWN) ? accWrite
                                                       : cycWrite;
                writeStrobe_n <= (state == `EBC_ST_OWN) ? ~accWrite
                                                        : ~cycWrite;
            end else begin
                readStrobe_n <= 1'b1;
                writeStrobe_n <= 1'b1;
            end
            // Busy driven while owning; one high cycle before release, except in standby where it is released at once.
            if (next_state != `EBC_ST_IDLE &&
                next_state != `EBC_ST_WAITBB) begin
                busBusyOut_n <= 1'b0;
                busBusyOe <= 1'b1;
                busBusyRelease <= 1'b1;
            end else if (busBusyRelease) begin
                busBusyOut_n <= 1'b1;
                busBusyOe <= ~standby;
                busBusyRelease <= 1'b0;
            end else begin
                busBusyOut_n <= 1'b1;
                busBusyOe <= 1'b0;
            end
        end
    end

    // Acknowledge outside a cycle has no path into the state machine.

endmodule

`default_nettype wire

/* File: test/ebc_bus_control_props.sv */
// Purpose: Checker for the external bus control pins.
// Assumes: One clock domain; sees only the top module ports.
// Notes:   Bound to the design from the testbench top file.
`default_nettype none
// ==========================================================
// Checker
module ebc_bus_control_props #(
    parameter ATTR_W = 4,
    parameter WS_W = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic accDram,
    input wire logic accDone,
    input wire logic busOwner,
    input wire logic attrPriorityDisable,
    input wire logic rowStrobeMode,
    input wire logic ackSyncSelect,
    input wire logic requestHold,
    input wire logic [WS_W-1:0] waitStates,
    input wire logic standby,
    input wire logic [ATTR_W-1:0] addressAttributeOut,
    input wire logic addressAttributeOe,
    input wire logic readStrobe_n,
    input wire logic writeStrobe_n,
    input wire logic strobeOe,
    input wire logic transferAck_n,
    input wire logic busRequest_n,
    input wire logic busGrant_n,
    input wire logic busBusyIn_n,
    input wire logic busBusyOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [WS_W+1:0] lowCnt;
    wire strobing = !(readStrobe_n && writeStrobe_n);
    // Attribute lines are judged while a strobe is low; a parked bus may
    // still show the pattern of a cycle run in another mode.
    wire prioMode = addressAttributeOe && !attrPriorityDisable &&
        !rowStrobeMode && strobing;
    // Counts edges with a strobe low before the cycle completes.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) lowCnt <= '0;
        else if (!strobing) lowCnt <= '0;
        else if (!accDone) lowCnt <= lowCnt + 1'b1;
    end
    // A synchronous-mode cycle still held off by the responder.
    sequence heldOff;
        ackSyncSelect && transferAck_n && strobing && !accDone &&
            !accDram && waitStates != '0;
    endsequence
    // Ownership taken at this edge.
    sequence gained;
        !busOwner ##1 busOwner;
    endsequence
    chk_attr_one_hot: assert property (prioMode |->
        $onehot0(addressAttributeOut)) else $error("attribute not one-hot");
    chk_strobe_owner: assert property (strobing |->
        busOwner && strobeOe) else $error("strobe low while not owner");
    chk_ack_stretch: assert property (heldOff |=> !accDone)
        else $error("cycle ended with ack held off");
    chk_ack_sync: assert property (accDone && ackSyncSelect &&
        waitStates != '0 && !accDram |-> !$past(transferAck_n))
        else $error("sync cycle ended without ack");
    chk_min_waits: assert property (accDone |->
        lowCnt >= {2'b00, waitStates}) else $error("cycle shorter than waits");
    chk_ack_async: assert property (accDone && !ackSyncSelect &&
        waitStates != '0 && !accDram |-> !$past(transferAck_n, 3))
        else $error("async cycle ended too early");
    chk_req_hold: assert property ((requestHold && !standby) [*2]
        |-> !busRequest_n) else $error("request not held");
    chk_standby_req: assert property ((standby && !requestHold) [*2]
        |-> busRequest_n) else $error("request left on in standby");
    chk_standby_off: assert property (standby [*2] |-> !busOwner &&
        !strobeOe && !busBusyOe && !addressAttributeOe)
        else $error("pins driven in standby");
    chk_take_free: assert property (gained |->
        $past(!busGrant_n && busBusyIn_n)) else $error("took a busy bus");
endmodule
`default_nettype wire

/* File: test/ebc_far_side.sv */
// Purpose: Model of the memories and arbiter beyond the port.
// Assumes: Changes its grant and acknowledge outputs on the falling edge of clk.
// Notes:   The busy line has a pull-up; another master may pull it.
`default_nettype none
// ==========================================================
// Far side model
module ebc_far_side (
    input wire logic clk,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic oe,
    input wire logic reqN,
    input wire logic busyOutN,
    input wire logic busyOe,
    input wire logic holdOff,
    input wire logic otherBusy,
    input wire logic noAck,
    input wire logic [3:0] ackDelay,
    output var logic grantN = 1'b1,
    output wire logic busyN,
    output var logic ackN = 1'b1
);
    logic [3:0] cnt = 4'h0;
    // Wired busy line: pull-up unless someone drives it.
    assign busyN = busyOe ? busyOutN : !otherBusy;
    // Arbiter parks the grant until another master wants the bus.
    always @(negedge clk) begin
        if (holdOff) grantN <= 1'b1;
        else if (!reqN) grantN <= 1'b0;
    end
    // Acknowledge after ackDelay strobe cycles; never while noAck is set (DRAM accesses).
    always @(negedge clk) begin
        if (oe && !(rdN && wrN) && !noAck && cnt == ackDelay) begin
            ackN <= 1'b0;
        end else if (oe && !(rdN && wrN)) begin
            cnt <= cnt + 4'h1;
        end else begin
            ackN <= 1'b1;
            cnt <= 4'h0;
        end
    end
endmodule
`default_nettype wire

/* File: test/test_ebc_bus_control.sv */
// Purpose: Self-checking bench for the external bus control block.
// Assumes: 40 MHz clock; inputs change on the falling edge.
// Notes:   The far-side model grants the bus and acknowledges.
`default_nettype none
// ==========================================================
// Bench top
module test_ebc_bus_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, sys_rst = 1'b1, accReq = 1'b0, accExternal = 1'b1;
    logic accWrite = 1'b0, accDram = 1'b0, prioDis = 1'b0, rowMode = 1'b0;
    logic syncSel = 1'b1, reqHold = 1'b0, standby = 1'b0, holdOff = 1'b0;
    logic otherBusy = 1'b0;
    logic [3:0] accAttr = 4'h6, rowPol = 4'h5, waitSt = 4'h1, ackDelay = 4'h0;
    wire accDone, busOwner, attrOe, rdN, wrN, strobeOe, ackN, reqN, grantN;
    wire busyInN, busyOutN, busyOe;
    wire [3:0] attrOut;
    int n_errors = 0, total_checks = 0;
    // Core clock, 25 ns period.
    always #12.5 clk = ~clk;
    // Design with the far-side model.
    ebc_bus_control i_ebc_bus_control (.clk(clk), .sys_rst(sys_rst),
        .accReq(accReq), .accExternal(accExternal), .accWrite(accWrite),
        .accAttr(accAttr), .accDram(accDram), .accDone(accDone),
        .busOwner(busOwner), .attrPriorityDisable(prioDis),
        .rowStrobeMode(rowMode), .rowStrobeActiveHigh(rowPol),
        .ackSyncSelect(syncSel), .requestHold(reqHold), .parkEnable(1'b1),
        .waitStates(waitSt), .standby(standby),
        .addressAttributeOut(attrOut), .addressAttributeOe(attrOe),
        .readStrobe_n(rdN), .writeStrobe_n(wrN), .strobeOe(strobeOe),
        .transferAck_n(ackN), .busRequest_n(reqN), .busGrant_n(grantN),
        .busBusyIn_n(busyInN), .busBusyOut_n(busyOutN), .busBusyOe(busyOe));
    ebc_far_side i_ebc_far_side (.clk(clk), .rdN(rdN), .wrN(wrN),
        .oe(strobeOe), .reqN(reqN), .busyOutN(busyOutN), .busyOe(busyOe),
        .holdOff(holdOff), .otherBusy(otherBusy), .noAck(accDram),
        .ackDelay(ackDelay), .grantN(grantN), .busyN(busyInN), .ackN(ackN));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One external access; counts strobe-low cycles up to completion.
    task automatic doAcc(input logic wr, input logic [3:0] ws, d,
            input logic [7:0] expLow, input logic [3:0] expAttr);
        logic [7:0] n;
        logic [1:0] sb;
        n = 8'h00;
        sb = 2'b11;
        accWrite = wr;
        waitSt = ws;
        ackDelay = d;
        accReq = 1'b1;
        for (int i = 0; i < 80 && accDone !== 1'b1; i++) begin
            @(negedge clk);
            // Strobes of a cycle with waits rise at the edge entering completion, so keep the
            // pattern seen while they were low.
            if (rdN === 1'b0 || wrN === 1'b0) begin
                n++;
                sb = {rdN, wrN};
            end
        end
        if (accDone !== 1'b1) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            tally_and_finish();
        end
        accReq = 1'b0;
        cmp(n, expLow);
        cmp(sb, wr ? 2'b10 : 2'b01);
        cmp(attrOut, expAttr);
        @(negedge clk);
    endtask
    // Internal accesses leave the request line alone.
    task automatic scInternal();
        accExternal = 1'b0;
        accReq = 1'b1;
        repeat (10) @(negedge clk);
        cmp({reqN, busOwner}, 2'b10);
        accReq = 1'b0;
        accExternal = 1'b1;
    endtask
    // Wait states, stretching, both sampling modes, DRAM and zero wait.
    task automatic scCycles();
        doAcc(1'b0, 4'h1, 4'h0, 8'h02, 4'h2);
        doAcc(1'b1, 4'h2, 4'h0, 8'h03, 4'h2);
        doAcc(1'b0, 4'h1, 4'h5, 8'h06, 4'h2);
        doAcc(1'b1, 4'h6, 4'h0, 8'h07, 4'h2);
        syncSel = 1'b0;
        doAcc(1'b0, 4'h1, 4'h2, 8'h05, 4'h2);
        syncSel = 1'b1;
        accDram = 1'b1;
        doAcc(1'b1, 4'h2, 4'h0, 8'h03, 4'h2);
        accDram = 1'b0;
        doAcc(1'b0, 4'h0, 4'hf, 8'h01, 4'h2);
    endtask
    // Priority, encoded and row strobe attribute modes.
    task automatic scModes();
        logic [3:0] expA [3] = '{4'h2, 4'h6, 4'hc};
        for (int m = 0; m < 3; m++) begin
            prioDis = (m == 1);
            rowMode = (m == 2);
            doAcc(1'b0, 4'h1, 4'h0, 8'h02, expA[m]);
        end
        prioDis = 1'b0;
        rowMode = 1'b0;
    endtask
    // Request drops while parked; losing the grant frees the busy line.
    task automatic scPark();
        repeat (3) @(negedge clk);
        cmp({reqN, busOwner}, 2'b11);
        holdOff = 1'b1;
        repeat (6) @(negedge clk);
        cmp({busOwner, busyOe, busyInN}, 3'b001);
        holdOff = 1'b0;
    endtask
    // Grant while another master is busy must not take the bus.
    task automatic scArb();
        otherBusy = 1'b1;
        accReq = 1'b1;
        repeat (8) @(negedge clk);
        cmp({reqN, grantN, busOwner}, 3'b000);
        otherBusy = 1'b0;
        doAcc(1'b1, 4'h1, 4'h0, 8'h02, 4'h2);
    endtask
    // Request hold, then standby with and without it.
    task automatic scStandby();
        reqHold = 1'b1;
        repeat (3) @(negedge clk);
        cmp(reqN, 1'b0);
        standby = 1'b1;
        repeat (3) @(negedge clk);
        cmp({reqN, busOwner, strobeOe, busyOe, attrOe}, 5'h00);
        reqHold = 1'b0;
        repeat (3) @(negedge clk);
        cmp(reqN, 1'b1);
        standby = 1'b0;
    endtask
    // Main sequence, with a second reset at the end.
    initial begin
        repeat (10) @(negedge clk);
        cmp({reqN, busOwner, strobeOe, busyOe}, 4'h8);
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        scInternal();
        scCycles();
        scModes();
        scPark();
        scArb();
        scStandby();
        sys_rst = 1'b1;
        @(negedge clk);
        cmp({reqN, busOwner}, 2'b10);
        tally_and_finish();
    end
endmodule
bind ebc_bus_control ebc_bus_control_props #(.ATTR_W(ATTR_W), .WS_W(WS_W))
    i_ebc_bus_control_props (.clk(clk), .sys_rst(sys_rst), .accDram(accDram),
    .accDone(accDone), .busOwner(busOwner), .rowStrobeMode(rowStrobeMode),
    .attrPriorityDisable(attrPriorityDisable), .standby(standby),
    .ackSyncSelect(ackSyncSelect), .requestHold(requestHold),
    .waitStates(waitStates), .addressAttributeOut(addressAttributeOut),
    .addressAttributeOe(addressAttributeOe), .readStrobe_n(readStrobe_n),
    .writeStrobe_n(writeStrobe_n), .strobeOe(strobeOe),
    .transferAck_n(transferAck_n), .busRequest_n(busRequest_n),
    .busGrant_n(busGrant_n), .busBusyIn_n(busBusyIn_n), .busBusyOe(busBusyOe));
`default_nettype wire
